// ### dcec_channel.sv
// DMA channel control, event control and interrupt control slice with APB access
//
// Behaviour
// - Auto-enable set: channel stays on after block completes.
// - Auto-enable clear: channel turns off when block completes.
// - Read-only event flag shows a start or abort event was seen.
// - Two-bit priority field, value equals priority level 0..3.
// - Abort interrupt-number field bits 23:16, resets to all ones.
// - Start interrupt-number field bits 15:8, resets to all ones.
// - Abort stops the transfer and sets the transfer-abort flag.
// - Start-irq enable set: matching interrupt starts a cell transfer; here the transfer runs on to block end, not one cell.
// - Start-irq enable clear: start interrupt ignored.
// - Abort-irq enable set: matching interrupt aborts the transfer.
// - Abort-irq enable clear: abort interrupt ignored.
// - Writing one to force bit starts a transfer; reads zero.
// - Writing one to soft-abort bit aborts; reads zero.
// - Match-abort enable: pattern match aborts and clears channel on.
// - Eight interrupt enables at bits 23:16, reset zero.
// - Eight interrupt flags at bits 7:0, same order, reset zero.
// - Source-done flag when source pointer equals source size.
// - Source half flag when source pointer equals half source size.
// - Unimplemented bits read zero and ignore writes.
// - Destination-done flag when destination pointer equals its size.
// - Destination half flag at half the destination size.
// - Block-complete flag at larger size done or pattern match with match-abort enabled.
// - Cell-complete flag when cell size bytes transferred.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module dcec_channel #(
	parameter int IRQ_COUNT = 256
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [IRQ_COUNT-1:0] irq_in,
	input  wire logic        pattern_match,
	input  wire logic        byte_moved,
	input  wire logic        addr_error,
	output logic             xfer_start,
	output logic             xfer_abort,
	output logic             chan_running,
	output logic [1:0]       chan_priority,
	output logic             chan_irq
);
	// Eight-bit selectors can only address a vector of exactly 256 sources
	if (IRQ_COUNT != 256) begin : g_bad_count
		$error("IRQ_COUNT must be 256 for 8-bit selectors");
	end

	logic        chan_on_q, auto_reenable_q, event_seen_q;
	logic [1:0]  prio_q;
	logic [7:0]  abort_irq_select_q, start_irq_select_q;
	logic        match_abort_enable_q, start_irq_enable_q, abort_irq_enable_q;
	logic [7:0]  ie_q, flag_q, flag_d;
	logic [15:0] src_size_q, dst_size_q, cell_size_q;
	logic [15:0] src_pointer_q, dst_pointer_q, cell_cnt_q;
	dcec_pkg::dcec_state_t state_q;

	logic wr, rd_ok, wr_con, wr_econ, wr_int, wr_size, wr_csize;
	assign wr       = psel && penable && pwrite;
	assign wr_con   = wr && paddr == dcec_pkg::OFF_CON;
	assign wr_econ  = wr && paddr == dcec_pkg::OFF_ECON;
	assign wr_int   = wr && paddr == dcec_pkg::OFF_INT;
	assign wr_size  = wr && paddr == dcec_pkg::OFF_SIZE;
	assign wr_csize = wr && paddr == dcec_pkg::OFF_PTR;
	assign rd_ok    = paddr == dcec_pkg::OFF_CON || paddr == dcec_pkg::OFF_ECON ||
	                  paddr == dcec_pkg::OFF_INT || paddr == dcec_pkg::OFF_PTR ||
	                  paddr == dcec_pkg::OFF_SIZE;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !rd_ok;

	// Event decode: each selector picks one bit of the interrupt vector
	logic start_evt, abort_evt, running, block_end;
	logic [15:0] big_size;
	assign running   = state_q == dcec_pkg::DCEC_RUN;
	assign start_evt = (start_irq_enable_q && irq_in[start_irq_select_q]) ||
	                   (wr_econ && pstrb[0] && pwdata[dcec_pkg::ECON_FORCE]);
	assign abort_evt = (abort_irq_enable_q && irq_in[abort_irq_select_q]) ||
	                   (wr_econ && pstrb[0] && pwdata[dcec_pkg::ECON_ABORT]) ||
	                   (match_abort_enable_q && pattern_match);
	assign big_size  = (src_size_q > dst_size_q) ? src_size_q : dst_size_q;
	// Both sizes zero means 65536, so the counter wraps onto it
	assign block_end = running && byte_moved && !abort_evt &&
	                   (src_pointer_q + 16'h0001) == big_size;
	assign xfer_start   = start_evt && !abort_evt && chan_on_q && !running;
	assign xfer_abort   = abort_evt && running;
	assign chan_running = running;
	assign chan_priority = prio_q;
	assign chan_irq     = |(flag_q & ie_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= dcec_pkg::DCEC_IDLE;
		end else begin
			unique case (state_q)
				dcec_pkg::DCEC_IDLE: if (xfer_start) state_q <= dcec_pkg::DCEC_RUN;
				dcec_pkg::DCEC_RUN:  if (abort_evt || block_end || !chan_on_q) state_q <= dcec_pkg::DCEC_IDLE;
				default:             state_q <= dcec_pkg::DCEC_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_on_q       <= 1'b0;
			auto_reenable_q <= 1'b0;
			prio_q          <= 2'b00;
		end else begin
			if (wr_con && pstrb[0]) begin
				chan_on_q       <= pwdata[dcec_pkg::CON_ON];
				auto_reenable_q <= pwdata[dcec_pkg::CON_AUTO];
				prio_q          <= pwdata[1:0];
			end
			if (match_abort_enable_q && pattern_match)
				chan_on_q <= 1'b0;
			else if (block_end && !auto_reenable_q)
				chan_on_q <= 1'b0;
			// Auto-enable leaves chan_on_q untouched at block end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_seen_q <= 1'b0;
		end else if (start_evt || abort_evt) begin
			event_seen_q <= 1'b1;
		end else if (xfer_start || (wr_con && pstrb[0])) begin
			event_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_irq_select_q   <= dcec_pkg::IRQ_SEL_RST;
			start_irq_select_q   <= dcec_pkg::IRQ_SEL_RST;
			match_abort_enable_q <= 1'b0;
			start_irq_enable_q   <= 1'b0;
			abort_irq_enable_q   <= 1'b0;
		end else if (wr_econ) begin
			if (pstrb[2]) abort_irq_select_q <= pwdata[dcec_pkg::ECON_AIRQ_LSB +: 8];
			if (pstrb[1]) start_irq_select_q <= pwdata[dcec_pkg::ECON_SIRQ_LSB +: 8];
			if (pstrb[0]) begin
				match_abort_enable_q <= pwdata[dcec_pkg::ECON_PAT];
				start_irq_enable_q   <= pwdata[dcec_pkg::ECON_SIEN];
				abort_irq_enable_q   <= pwdata[dcec_pkg::ECON_AIEN];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_size_q  <= 16'h0000;
			dst_size_q  <= 16'h0000;
			cell_size_q <= 16'h0001;
		end else begin
			if (wr_size) begin
				src_size_q <= pwdata[15:0];
				dst_size_q <= pwdata[31:16];
			end
			if (wr_csize) cell_size_q <= pwdata[15:0];
		end
	end

	// Pointers count bytes moved; source and destination advance together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_pointer_q <= 16'h0000;
			dst_pointer_q <= 16'h0000;
			cell_cnt_q    <= 16'h0000;
		end else if (xfer_start && src_pointer_q == 16'h0000) begin
			cell_cnt_q <= 16'h0000;
		end else if (running && (abort_evt || block_end)) begin
			src_pointer_q <= 16'h0000;
			dst_pointer_q <= 16'h0000;
			cell_cnt_q    <= 16'h0000;
		end else if (running && byte_moved) begin
			src_pointer_q <= src_pointer_q + 16'h0001;
			dst_pointer_q <= dst_pointer_q + 16'h0001;
			cell_cnt_q    <= (cell_cnt_q + 16'h0001 == cell_size_q) ? 16'h0000 : cell_cnt_q + 16'h0001;
		end
	end

	logic [15:0] sp_n, dp_n;
	logic [7:0]  hw_set;
	assign sp_n = src_pointer_q + 16'h0001;
	assign dp_n = dst_pointer_q + 16'h0001;
	always_comb begin
		hw_set = 8'h00;
		if (running && byte_moved && !abort_evt) begin
			hw_set[dcec_pkg::F_SRC_DONE] = sp_n == src_size_q;
			hw_set[dcec_pkg::F_SRC_HALF] = sp_n == {1'b0, src_size_q[15:1]};
			hw_set[dcec_pkg::F_DST_DONE] = dp_n == dst_size_q;
			hw_set[dcec_pkg::F_DST_HALF] = dp_n == {1'b0, dst_size_q[15:1]};
			hw_set[dcec_pkg::F_CELL]     = cell_cnt_q + 16'h0001 == cell_size_q;
		end
		hw_set[dcec_pkg::F_BLOCK]    = block_end || (match_abort_enable_q && pattern_match);
		hw_set[dcec_pkg::F_ABORT]    = xfer_abort;
		hw_set[dcec_pkg::F_ADDR_ERR] = addr_error && running;
	end

	always_comb begin
		flag_d = flag_q;
		if (wr_int && pstrb[0])
			flag_d = pwdata[7:0];
		flag_d = flag_d | hw_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 8'h00;
			ie_q   <= 8'h00;
		end else begin
			flag_q <= flag_d;
			if (wr_int && pstrb[2])
				ie_q <= pwdata[dcec_pkg::INT_IE_LSB +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				dcec_pkg::OFF_CON: prdata <= {16'h0000, running, 7'h00, chan_on_q, 2'b00,
				                              auto_reenable_q, 1'b0, event_seen_q, prio_q};
				dcec_pkg::OFF_ECON: prdata <= {8'h00, abort_irq_select_q, start_irq_select_q, 2'b00,
				                               match_abort_enable_q, start_irq_enable_q, abort_irq_enable_q, 3'b000};
				dcec_pkg::OFF_INT:  prdata <= {8'h00, ie_q, 8'h00, flag_q};
				dcec_pkg::OFF_PTR:  prdata <= {src_pointer_q, cell_size_q};
				dcec_pkg::OFF_SIZE: prdata <= {dst_size_q, src_size_q};
				default:            prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Next-count compare shared by the flag checks below
	function automatic logic dcec_at(input logic [15:0] cnt, input logic [15:0] mark);
		return (cnt + 16'h0001) == mark;
	endfunction : dcec_at

	// Flags and state must follow each event on the very next edge
	a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(hw_set != 8'h00) |=> ((flag_q & $past(hw_set)) == $past(hw_set)))
		else $error("hardware flag set lost");
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_int && pstrb[0] && hw_set == 8'h00) |=> flag_q == $past(pwdata[7:0]))
		else $error("flag write not taken");
	a_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
		((|(hw_set & ie_q)) && !wr_int) |=> chan_irq)
		else $error("interrupt output missing");
	a_ie_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_int && pstrb[2]) |=> ie_q == $past(pwdata[23:16]))
		else $error("enable write not taken");
	a_abort_flag: assert property (@(posedge pclk) disable iff (!presetn)
		xfer_abort |=> flag_q[dcec_pkg::F_ABORT] && !running)
		else $error("abort did not stop channel");
	a_ptr_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(running && abort_evt) |=> src_pointer_q == 16'h0000)
		else $error("pointer kept after abort");
	a_block_off: assert property (@(posedge pclk) disable iff (!presetn)
		(block_end && !auto_reenable_q && !wr_con) |=> !chan_on_q)
		else $error("channel stayed on");
	a_block_auto: assert property (@(posedge pclk) disable iff (!presetn)
		(block_end && auto_reenable_q && chan_on_q && !wr_con && !pattern_match) |=> chan_on_q)
		else $error("auto enable lost");
	a_block_flag: assert property (@(posedge pclk) disable iff (!presetn)
		block_end |=> flag_q[dcec_pkg::F_BLOCK] && !running)
		else $error("block end not flagged");
	a_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(!start_irq_enable_q && !wr_econ) |-> !start_evt)
		else $error("start ignored enable");
	a_start_run: assert property (@(posedge pclk) disable iff (!presetn)
		xfer_start |=> running)
		else $error("start did not run");
	a_force_run: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_econ && pstrb[0] && pwdata[dcec_pkg::ECON_FORCE] && chan_on_q && !running && !abort_evt) |=> running)
		else $error("forced start lost");
	a_abort_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(!abort_irq_enable_q && !wr_econ && !match_abort_enable_q) |-> !abort_evt)
		else $error("abort ignored enable");
	a_soft_abort: assert property (@(posedge pclk) disable iff (!presetn)
		(running && wr_econ && pstrb[0] && pwdata[dcec_pkg::ECON_ABORT]) |=> !running)
		else $error("soft abort ignored");
	a_match_off: assert property (@(posedge pclk) disable iff (!presetn)
		(match_abort_enable_q && pattern_match) |=> !chan_on_q)
		else $error("match left channel on");
	a_off_stops: assert property (@(posedge pclk) disable iff (!presetn)
		(running && !chan_on_q) |=> !running)
		else $error("suspend did not stop");
	a_event_seen: assert property (@(posedge pclk) disable iff (!presetn)
		(start_evt || abort_evt) |=> event_seen_q)
		else $error("event flag not set");
	a_prio_out: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_con && pstrb[0]) |=> chan_priority == $past(pwdata[1:0]))
		else $error("priority not taken");
	a_asel_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_econ && pstrb[2]) |=> abort_irq_select_q == $past(pwdata[23:16]))
		else $error("abort select not taken");
	a_ssel_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_econ && pstrb[1]) |=> start_irq_select_q == $past(pwdata[15:8]))
		else $error("start select not taken");
	// Pointer compares use the incremented count (count plus one), as the flag logic does
	a_src_done: assert property (@(posedge pclk) disable iff (!presetn)
		(running && byte_moved && !abort_evt && dcec_at(src_pointer_q, src_size_q)) |=> flag_q[dcec_pkg::F_SRC_DONE])
		else $error("source done missing");
	a_src_half: assert property (@(posedge pclk) disable iff (!presetn)
		(running && byte_moved && !abort_evt && dcec_at(src_pointer_q, {1'b0, src_size_q[15:1]}))
		|=> flag_q[dcec_pkg::F_SRC_HALF])
		else $error("source half missing");
	a_dst_done: assert property (@(posedge pclk) disable iff (!presetn)
		(running && byte_moved && !abort_evt && dcec_at(dst_pointer_q, dst_size_q)) |=> flag_q[dcec_pkg::F_DST_DONE])
		else $error("destination done missing");
	a_dst_half: assert property (@(posedge pclk) disable iff (!presetn)
		(running && byte_moved && !abort_evt && dcec_at(dst_pointer_q, {1'b0, dst_size_q[15:1]}))
		|=> flag_q[dcec_pkg::F_DST_HALF])
		else $error("destination half missing");
	a_cell_done: assert property (@(posedge pclk) disable iff (!presetn)
		(running && byte_moved && !abort_evt && dcec_at(cell_cnt_q, cell_size_q)) |=> flag_q[dcec_pkg::F_CELL])
		else $error("cell done missing");
	a_econ_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == dcec_pkg::OFF_ECON) |=> prdata[7:6] == 2'b00 && prdata[31:24] == 8'h00)
		else $error("settable bits read nonzero");
	a_con_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == dcec_pkg::OFF_CON) |=> prdata[31:16] == 16'h0000 && prdata[3] == 1'b0)
		else $error("control spare bits nonzero");
	a_int_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == dcec_pkg::OFF_INT) |=> prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00)
		else $error("interrupt spare bits nonzero");

	c_start: cover property (@(posedge pclk) disable iff (!presetn) xfer_start);
	c_block: cover property (@(posedge pclk) disable iff (!presetn) block_end);
	c_abort: cover property (@(posedge pclk) disable iff (!presetn) xfer_abort);
	c_set_clear: cover property (@(posedge pclk) disable iff (!presetn) wr_int && hw_set != 8'h00);
	c_auto: cover property (@(posedge pclk) disable iff (!presetn) block_end && auto_reenable_q);
endmodule : dcec_channel

// ### dcec_pkg.sv
// Package: register map, field positions and reset values for the DMA channel event slice
package dcec_pkg;
	localparam logic [11:0] OFF_CON  = 12'h000;
	localparam logic [11:0] OFF_ECON = 12'h004;
	localparam logic [11:0] OFF_INT  = 12'h008;
	localparam logic [11:0] OFF_PTR  = 12'h00C;
	localparam logic [11:0] OFF_SIZE = 12'h010;
	localparam int CON_ON     = 7;
	localparam int CON_AUTO   = 4;
	localparam int CON_EVT    = 2;
	localparam int CON_ACTIVE = 15;
	localparam int ECON_FORCE = 7;
	localparam int ECON_ABORT = 6;
	localparam int ECON_PAT   = 5;
	localparam int ECON_SIEN  = 4;
	localparam int ECON_AIEN  = 3;
	localparam int ECON_SIRQ_LSB = 8;
	localparam int ECON_AIRQ_LSB = 16;
	localparam int INT_IE_LSB = 16;
	localparam logic [7:0] IRQ_SEL_RST = 8'hFF;
	localparam int F_SRC_DONE = 7;
	localparam int F_SRC_HALF = 6;
	localparam int F_DST_DONE = 5;
	localparam int F_DST_HALF = 4;
	localparam int F_BLOCK    = 3;
	localparam int F_CELL     = 2;
	localparam int F_ABORT    = 1;
	localparam int F_ADDR_ERR = 0;
	typedef enum logic [1:0] {
		DCEC_IDLE = 2'b01,
		DCEC_RUN  = 2'b10
	} dcec_state_t;
endpackage : dcec_pkg

// ### dcec_far_model.sv
// Far-side model: interrupt sources and byte mover for one channel
`timescale 1ns/1ps
module dcec_far_model (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [7:0]   irq_num,
	input  wire logic         irq_fire,
	input  wire logic         slow,
	input  wire logic         chan_running,
	output logic      [255:0] irq_in,
	output logic              byte_moved
);
	logic [1:0] pace_q;
	always_comb begin
		irq_in = irq_fire ? (256'h1 << irq_num) : 256'h0;
		// Slow mode stalls three cycles in four
		byte_moved = chan_running && (!slow || pace_q == 2'h3);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pace_q <= 2'h0;
		else
			pace_q <= pace_q + 2'h1;
	end
endmodule : dcec_far_model

// ### dma_channel_event_irq_control_tb.sv
// Self-checking bench for the DMA channel event and interrupt slice
`timescale 1ns/1ps
module dma_channel_event_irq_control_tb;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} dcec_row_t;
	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [7:0]   irq_num = 8'h00;
	logic         irq_fire = 1'b0;
	logic         slow = 1'b1;
	logic         pat = 1'b0;
	logic [31:0]  prdata, rd;
	logic         pready, pslverr, err, running, cirq, bmove;
	logic [1:0]   prio;
	logic [255:0] irqs;
	logic         xstart, xabort;
	int           n_start = 0;
	int           n_abort = 0;
	int           mismatches = 0;
	int           n_tests = 0;
	dcec_row_t    rows [6] = '{'{12'h004, 32'hFFFF_FF38, 32'h00FF_FF38}, '{12'h004, 32'h0009_0500, 32'h0009_0500},
		'{12'h000, 32'h0000_0017, 32'h0000_0013}, '{12'h008, 32'hFFFF_FF00, 32'h00FF_0000},
		'{12'h008, 32'h0000_0000, 32'h0000_0000}, '{12'h014, 32'h1234_5678, 32'h0000_0000}};
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (xstart === 1'b1) n_start++;
		if (xabort === 1'b1) n_abort++;
	end
	dcec_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_in(irqs), .pattern_match(pat), .byte_moved(bmove), .addr_error(1'b0), .xfer_start(xstart),
		.xfer_abort(xabort), .chan_running(running), .chan_priority(prio), .chan_irq(cirq));
	dcec_far_model i_far (.pclk(pclk), .presetn(presetn), .irq_num(irq_num), .irq_fire(irq_fire),
		.slow(slow), .chan_running(running), .irq_in(irqs), .byte_moved(bmove));
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(n, rd & m, e);
	endtask : rc
	task automatic fire(input logic [7:0] n);
		irq_num <= n;
		irq_fire <= 1'b1;
		@(posedge pclk);
		irq_fire <= 1'b0;
		@(posedge pclk);
	endtask : fire
	task automatic wait_idle();
		int k;
		k = 0;
		while (running !== 1'b0 && k < 300) begin
			@(posedge pclk);
			k++;
		end
	endtask : wait_idle
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		end_of_test();
	end
	initial begin
		int k;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("econ_rst", 12'h004, 32'hFFFF_FFFF, 32'h00FF_FF00);
		rc("int_rst", 12'h008, 32'hFFFF_FFFF, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			rc("row", rows[i].a, 32'hFFFF_FFFF, rows[i].r);
		end
		check("unmapped", {31'h0, err}, 32'h1);
		for (k = 0; k < 4; k++) begin
			apb(1'b1, 12'h000, k);
			check("prio", {30'h0, prio}, k);
		end
		apb(1'b1, 12'h010, 32'h0008_0008);
		apb(1'b1, 12'h00C, 32'h0000_0004);
		apb(1'b1, 12'h000, 32'h0000_0080);
		fire(8'h05);
		check("start_off", {31'h0, running}, 32'h0);
		apb(1'b1, 12'h004, 32'h0009_0510);
		fire(8'h05);
		check("start_on", {31'h0, running}, 32'h1);
		rc("event", 12'h000, 32'h4, 32'h4);
		wait_idle();
		rc("flags", 12'h008, 32'hFF, 32'hFC);
		rc("on_clr", 12'h000, 32'h80, 32'h0);
		apb(1'b1, 12'h008, 32'h0002_00FC);
		check("irq_mask", {31'h0, cirq}, 32'h0);
		apb(1'b1, 12'h008, 32'h0008_00FC);
		check("irq_on", {31'h0, cirq}, 32'h1);
		apb(1'b1, 12'h008, 32'h0008_0000);
		check("irq_off", {31'h0, cirq}, 32'h0);
		slow <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0090);
		apb(1'b1, 12'h004, 32'h0009_0580);
		check("force", {31'h0, running}, 32'h1);
		rc("w1_read", 12'h004, 32'hC0, 32'h0);
		wait_idle();
		rc("auto_on", 12'h000, 32'h80, 32'h80);
		slow <= 1'b1;
		apb(1'b1, 12'h004, 32'h0009_0580);
		fire(8'h09);
		check("abort_off", {31'h0, running}, 32'h1);
		apb(1'b1, 12'h004, 32'h0009_0508);
		fire(8'h09);
		check("abort_on", {31'h0, running}, 32'h0);
		rc("abort_flag", 12'h008, 32'h2, 32'h2);
		apb(1'b1, 12'h004, 32'h0009_0580);
		apb(1'b1, 12'h004, 32'h0009_0540);
		check("soft_abort", {31'h0, running}, 32'h0);
		apb(1'b1, 12'h008, 32'h0008_0000);
		apb(1'b1, 12'h004, 32'h0009_05A0);
		pat <= 1'b1;
		@(posedge pclk);
		pat <= 1'b0;
		@(posedge pclk);
		check("match", {31'h0, running}, 32'h0);
		rc("match_on", 12'h000, 32'h80, 32'h0);
		rc("match_blk", 12'h008, 32'h8, 32'h8);
		check("match_irq", {31'h0, cirq}, 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0090);
		apb(1'b1, 12'h004, 32'h0009_0580);
		apb(1'b1, 12'h000, 32'h0000_0010);
		k = 0;
		// Suspension may lag the enable clear
		do begin
			apb(1'b0, 12'h000, 32'h0);
			k++;
		end while (rd[15] !== 1'b0 && k < 20);
		check("busy", rd & 32'h8000, 32'h0);
		apb(1'b1, 12'h000, 32'h0000_0080);
		apb(1'b1, 12'h004, 32'h0009_0580);
		check("n_start", n_start, 32'd7);
		check("n_abort", n_abort, 32'd3);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("rst_run", {31'h0, running}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("econ_rst2", 12'h004, 32'hFFFF_FFFF, 32'h00FF_FF00);
		end_of_test();
	end
endmodule : dma_channel_event_irq_control_tb
